// file: rtl/sicmc_core.v
// Purpose: Executes the supervisor-level system, move and memory control
//   instructions: raises exceptions, moves machine state, segment and
//   special registers, and issues cache and translation buffer commands.
// Assumes: One operation is issued at a time; i_issue is held off while
//   o_busy is high. Translation results arrive with the issue.
// Notes: Segment registers live here; special registers are reached over
//   a simple select and strobe port toward the register owner.
//   Only one operation is in flight at a time. An issue that arrives
//   while a drain or a sync stall is in progress is dropped, so the
//   issuing stage must watch o_busy. This keeps the sequencer small at
//   the cost of no overlap between supervisor operations.
//
// Overview of operation
// - System call raises the system call exception.
// - System call drains pipeline before later fetches.
// - Exception return completes at end, then redirects.
// - Move to and from machine state register.
// - Move to and from special purpose registers.
// - Cache invalidate on hit, no write back.
// - Broadcast invalidate only when broadcast enable set.
// - Invalidate uses store-type translation and protection.
// - Invalidate runs with data cache disabled or locked.
// - Block translation fault outranks buffer fault.
// - Direct-store segment makes cache operation a no-op.
// - Segment moves ignore translation enable bits.
// - Select bit reads instruction-side shadow segment copy.
// - Buffer invalidate both ways at address index.
// - Buffer sync stalls until sync input inactive.
// - Invalidate-all raises illegal instruction exception.
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
`include "sicmc_defs.vh"
module sicmc_core #(
  parameter SR_COUNT = 16,
  parameter SPR_ADDR_W = 10
) (
  // Clock and reset.
  input wire i_core_clk,
  input wire i_rst_n,
  // Issue port.
  input wire i_issue,
  input wire [`SICMC_OP_W-1:0] i_op,
  input wire i_user_mode,
  input wire [31:0] i_gpr_data,
  input wire [31:0] i_ea,
  input wire [SPR_ADDR_W-1:0] i_spr_num,
  input wire [3:0] i_sr_num,
  input wire i_sr_indirect,
  input wire i_pipe_empty,
  input wire [31:0] i_saved_msr,
  // Translation results for the effective address.
  input wire i_bat_prot_fault,
  input wire i_tlb_prot_fault,
  input wire i_direct_store,
  // Configuration bits from the implementation register.
  input wire i_address_broadcast_enable,
  input wire i_read_instruction_segment_select,
  // External pin.
  input wire i_translation_invalidate_sync_n,
  // Special register access port.
  input wire [31:0] i_spr_rdata,
  output reg o_spr_wr,
  output reg o_spr_rd,
  output reg [SPR_ADDR_W-1:0] o_spr_num,
  output reg [31:0] o_spr_wdata,
  // Cache and translation buffer commands.
  output reg o_dc_invalidate,
  output reg o_bus_broadcast,
  output reg [31:0] o_dc_addr,
  output reg o_tlb_invalidate,
  output reg [5:0] o_tlb_index,
  // Result and flow control.
  output reg o_done,
  output reg o_gpr_we,
  output reg [31:0] o_gpr_wdata,
  output reg [`SICMC_EXC_W-1:0] o_exception,
  output reg o_redirect,
  output reg o_hold_fetch,
  output wire o_busy,
  output reg [31:0] o_msr,
  output wire o_instruction_translation_enable,
  output wire o_data_translation_enable
);
  localparam ST_IDLE = 4'b0001;
  localparam ST_DRAIN = 4'b0010;
  localparam ST_SYNC = 4'b0100;
  localparam ST_SPRRD = 4'b1000;

  reg [3:0] state_q;
  reg [`SICMC_OP_W-1:0] op_q;
  reg [31:0] data_sr_q [0:SR_COUNT-1];
  reg [31:0] inst_sr_q [0:SR_COUNT-1];
  reg sync_meta_q;
  reg sync_q;
  wire [3:0] sr_sel;
  wire privileged;
  wire take;
  wire refused;
  wire go;
  wire op_ctx_sync;
  wire sr_write;
  wire dc_noop;
  wire dc_fault;
  wire [31:0] sr_read_data;

  assign sr_sel = i_sr_indirect ? i_ea[`SICMC_EA_SR_HI:`SICMC_EA_SR_LO] :
    i_sr_num;
  assign privileged = (i_op != `SICMC_OP_SYSCALL) &&
    (i_op != `SICMC_OP_NOP);
  assign o_busy = (state_q != ST_IDLE);
  assign o_instruction_translation_enable = o_msr[`SICMC_MSR_ITE_BIT];
  assign o_data_translation_enable = o_msr[`SICMC_MSR_DTE_BIT];

  // An issue is only taken while the sequencer is idle.
  assign take = (state_q == ST_IDLE) && i_issue;
  // User mode may only ask for a system call or a no-op; all else is refused.
  assign refused = i_user_mode && privileged;
  assign go = take && !refused;
  assign op_ctx_sync = (i_op == `SICMC_OP_SYSCALL) ||
    (i_op == `SICMC_OP_RETEXC);
  assign sr_write = go && (i_op == `SICMC_OP_MTSR);
  // A direct-store address turns the invalidate into a no-op, ahead of
  // any protection result.
  assign dc_noop = (i_op == `SICMC_OP_DCINV) && i_direct_store;
  assign dc_fault = (i_op == `SICMC_OP_DCINV) && !i_direct_store &&
    (i_bat_prot_fault || i_tlb_prot_fault);
  // The shadow copy is only visible through the select bit.
  assign sr_read_data = i_read_instruction_segment_select ?
    inst_sr_q[sr_sel] : data_sr_q[sr_sel];

  // The sync pin comes from off chip, so it is retimed twice first.
  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      sync_meta_q <= 1'b1;
      sync_q <= 1'b1;
    end else begin
      sync_meta_q <= i_translation_invalidate_sync_n;
      sync_q <= sync_meta_q;
    end
  end

  // Both segment copies are written together so the shadow stays coherent.
  genvar g;
  generate
    for (g = 0; g < SR_COUNT; g = g + 1) begin : g_sr
      always @(posedge i_core_clk) begin
        if (!i_rst_n) begin
          data_sr_q[g] <= `SICMC_SR_RESET;
          inst_sr_q[g] <= `SICMC_SR_RESET;
        end else if (sr_write && sr_sel == g) begin
          data_sr_q[g] <= i_gpr_data;
          inst_sr_q[g] <= i_gpr_data;
        end
      end
    end
  endgenerate

  // The machine state register has its own process so that both writers,
  // the move and the exception return, sit side by side.
  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_msr <= `SICMC_MSR_RESET;
    end else if (go && i_op == `SICMC_OP_MTMSR) begin
      o_msr <= i_gpr_data;
    end else if (state_q == ST_DRAIN && i_pipe_empty &&
                 op_q == `SICMC_OP_RETEXC) begin
      o_msr <= i_saved_msr;
    end
  end

  // Fetch is held from the issue of a context-synchronizing operation
  // until it completes, so nothing later runs in the old context.
  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_hold_fetch <= 1'b0;
    end else if (go && op_ctx_sync) begin
      o_hold_fetch <= 1'b1;
    end else if (state_q == ST_DRAIN && i_pipe_empty) begin
      o_hold_fetch <= 1'b0;
    end
  end

  // Translation buffer command: one pulse per invalidate-entry, with the
  // set index taken from the effective address.
  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_tlb_invalidate <= 1'b0;
      o_tlb_index <= 6'h00;
    end else begin
      o_tlb_invalidate <= go && (i_op == `SICMC_OP_TLBINV);
      if (go && i_op == `SICMC_OP_TLBINV) begin
        o_tlb_index <= i_ea[`SICMC_TLB_IDX_HI:`SICMC_TLB_IDX_LO];
      end
    end
  end

  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      state_q <= ST_IDLE;
      op_q <= `SICMC_OP_NOP;
      o_spr_wr <= 1'b0;
      o_spr_rd <= 1'b0;
      o_spr_num <= {SPR_ADDR_W{1'b0}};
      o_spr_wdata <= 32'h0000_0000;
      o_dc_invalidate <= 1'b0;
      o_bus_broadcast <= 1'b0;
      o_dc_addr <= 32'h0000_0000;
      o_done <= 1'b0;
      o_gpr_we <= 1'b0;
      o_gpr_wdata <= 32'h0000_0000;
      o_exception <= `SICMC_EXC_NONE;
      o_redirect <= 1'b0;
    end else begin
      o_spr_wr <= 1'b0;
      o_spr_rd <= 1'b0;
      o_dc_invalidate <= 1'b0;
      o_bus_broadcast <= 1'b0;
      o_done <= 1'b0;
      o_gpr_we <= 1'b0;
      o_exception <= `SICMC_EXC_NONE;
      o_redirect <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (take) begin
            op_q <= i_op;
            if (refused) begin
              o_exception <= `SICMC_EXC_PRIV;
              o_done <= 1'b1;
            end else if (op_ctx_sync) begin
              state_q <= ST_DRAIN;
            end else if (i_op == `SICMC_OP_TLBSYNC) begin
              state_q <= ST_SYNC;
            end else if (i_op == `SICMC_OP_MFSPR) begin
              o_spr_rd <= 1'b1;
              o_spr_num <= i_spr_num;
              state_q <= ST_SPRRD;
            end else begin
              o_done <= 1'b1;
              case (i_op)
                `SICMC_OP_MFMSR: begin
                  o_gpr_we <= 1'b1;
                  o_gpr_wdata <= o_msr;
                end
                `SICMC_OP_MTSPR: begin
                  o_spr_wr <= 1'b1;
                  o_spr_num <= i_spr_num;
                  o_spr_wdata <= i_gpr_data;
                end
                `SICMC_OP_DCINV: begin
                  // Cache state is ignored: enable and lock do not gate.
                  if (dc_noop) begin
                    o_exception <= `SICMC_EXC_NONE;
                  end else if (dc_fault) begin
                    o_exception <= `SICMC_EXC_DSI;
                  end else begin
                    o_dc_invalidate <= 1'b1;
                    o_dc_addr <= i_ea;
                    o_bus_broadcast <= i_address_broadcast_enable;
                  end
                end
                `SICMC_OP_MFSR: begin
                  o_gpr_we <= 1'b1;
                  o_gpr_wdata <= sr_read_data;
                end
                `SICMC_OP_TLBINVALL:
                  o_exception <= `SICMC_EXC_ILLEGAL;
                default: o_exception <= `SICMC_EXC_NONE;
              endcase
            end
          end
        end
        ST_DRAIN: begin
          if (i_pipe_empty) begin
            o_done <= 1'b1;
            o_redirect <= 1'b1;
            state_q <= ST_IDLE;
            if (op_q == `SICMC_OP_SYSCALL) begin
              o_exception <= `SICMC_EXC_SYSCALL;
            end
          end
        end
        ST_SYNC: begin
          if (sync_q) begin
            o_done <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
        ST_SPRRD: begin
          o_done <= 1'b1;
          o_gpr_we <= 1'b1;
          o_gpr_wdata <= i_spr_rdata;
          state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
endmodule

// file: inc/sicmc_defs.vh
// Purpose: Constants for the supervisor instruction and memory control block.
// Assumes: 32-bit instruction words, big-endian bit numbering in the docs.
// Notes: Opcode values are internal operation codes chosen for this block.
`ifndef SICMC_DEFS_VH
`define SICMC_DEFS_VH
// Operation codes presented on the issue port.
`define SICMC_OP_W 4
`define SICMC_OP_NOP 4'h0
`define SICMC_OP_SYSCALL 4'h1
`define SICMC_OP_RETEXC 4'h2
`define SICMC_OP_MTMSR 4'h3
`define SICMC_OP_MFMSR 4'h4
`define SICMC_OP_MTSPR 4'h5
`define SICMC_OP_MFSPR 4'h6
`define SICMC_OP_DCINV 4'h7
`define SICMC_OP_MTSR 4'h8
`define SICMC_OP_MFSR 4'h9
`define SICMC_OP_TLBINV 4'ha
`define SICMC_OP_TLBSYNC 4'hb
`define SICMC_OP_TLBINVALL 4'hc
// Exception cause codes.
`define SICMC_EXC_W 3
`define SICMC_EXC_NONE 3'h0
`define SICMC_EXC_SYSCALL 3'h1
`define SICMC_EXC_DSI 3'h2
`define SICMC_EXC_ILLEGAL 3'h3
`define SICMC_EXC_PRIV 3'h4
// Field positions and reset values.
`define SICMC_TLB_IDX_HI 17
`define SICMC_TLB_IDX_LO 12
`define SICMC_SR_IDX_HI 3
`define SICMC_SR_IDX_LO 0
`define SICMC_EA_SR_HI 31
`define SICMC_EA_SR_LO 28
`define SICMC_MSR_RESET 32'h0000_0000
`define SICMC_SR_RESET 32'h0000_0000
`define SICMC_MSR_ITE_BIT 5
`define SICMC_MSR_DTE_BIT 4
`endif

// file: test/sicmc_checker.sv
// Purpose: Port assertions for the supervisor instruction block.
// Assumes: One clock, synchronous active-low reset.
// Notes: Sees only the top module's ports.
`timescale 1ns/100ps
`include "sicmc_defs.vh"
module sicmc_checker (
  // Clock, reset and issue.
  input wire i_core_clk,
  input wire i_rst_n,
  input wire i_issue,
  input wire [`SICMC_OP_W-1:0] i_op,
  input wire i_user_mode,
  input wire [31:0] i_ea,
  input wire i_pipe_empty,
  input wire i_bat_prot_fault,
  input wire i_tlb_prot_fault,
  input wire i_direct_store,
  input wire i_address_broadcast_enable,
  input wire i_translation_invalidate_sync_n,
  // Results.
  input wire o_busy,
  input wire o_done,
  input wire [`SICMC_EXC_W-1:0] o_exception,
  input wire o_dc_invalidate,
  input wire o_bus_broadcast,
  input wire o_tlb_invalidate,
  input wire [5:0] o_tlb_index,
  input wire o_spr_rd,
  input wire o_gpr_we,
  input wire o_redirect,
  input wire o_hold_fetch
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_take(op);
    i_issue && !o_busy && !i_user_mode && i_op == op;
  endsequence
  sequence s_dcinv;
    s_take(`SICMC_OP_DCINV) ##0 !i_direct_store;
  endsequence
  // The pin must be low long enough to pass the synchronizer first.
  sequence s_sync_wait;
    !i_translation_invalidate_sync_n[*3] ##0 s_take(`SICMC_OP_TLBSYNC);
  endsequence
  sequence s_spr_read_done;
    o_spr_rd ##1 (o_done && o_gpr_we);
  endsequence
  a_spr_read: assert property (s_take(`SICMC_OP_MFSPR) |=> s_spr_read_done)
    else $error("special register read not completed");
  a_sc_hold: assert property (s_take(`SICMC_OP_SYSCALL) |=> o_hold_fetch)
    else $error("syscall did not hold fetch");
  a_drain_first: assert property (o_redirect |-> $past(i_pipe_empty))
    else $error("redirect before pipeline drained");
  a_bcast_gate: assert property (o_bus_broadcast |-> o_dc_invalidate && $past(i_address_broadcast_enable))
    else $error("broadcast without enable");
  a_dsi_fault: assert property (s_dcinv ##0 (i_bat_prot_fault || i_tlb_prot_fault) |=> o_exception == `SICMC_EXC_DSI && !o_dc_invalidate)
    else $error("protection fault not reported");
  a_noop_direct: assert property (s_take(`SICMC_OP_DCINV) ##0 i_direct_store |=> o_done && !o_dc_invalidate && o_exception == `SICMC_EXC_NONE)
    else $error("direct-store invalidate not a no-op");
  a_tlb_index: assert property (s_take(`SICMC_OP_TLBINV) |=> o_tlb_invalidate && o_tlb_index == $past(i_ea[`SICMC_TLB_IDX_HI:`SICMC_TLB_IDX_LO]))
    else $error("wrong translation buffer index");
  a_sync_stall: assert property (s_sync_wait |=> !o_done [*3])
    else $error("sync finished while pin active");
  a_illegal_all: assert property (s_take(`SICMC_OP_TLBINVALL) |=> o_done && o_exception == `SICMC_EXC_ILLEGAL)
    else $error("invalidate-all not illegal");
  a_priv_user: assert property (i_issue && !o_busy && i_user_mode && i_op > `SICMC_OP_SYSCALL |=> o_done && o_exception == `SICMC_EXC_PRIV)
    else $error("user mode not refused");
endmodule
bind sicmc_core sicmc_checker u_chk (.*);

// file: test/sicmc_tb.sv
// Purpose: Self-checking bench for the supervisor instruction block.
// Assumes: Every operation finishes within 40 cycles once unblocked.
// Notes: Table rows cover one-cycle outcomes; stalls are hand tests.
`timescale 1ns/100ps
`include "sicmc_defs.vh"
module testbench;
  typedef struct {logic [3:0] op; logic [4:0] f; logic [31:0] ea;
    logic [2:0] ex; logic [2:0] o;} sicmc_row_t;
  logic i_core_clk = 1'h0, i_rst_n = 1'h0, i_issue = 1'h0;
  logic i_user_mode = 1'h0, i_sr_indirect = 1'h0, i_pipe_empty = 1'h1;
  logic i_bat_prot_fault = 1'h0, i_tlb_prot_fault = 1'h0;
  logic i_direct_store = 1'h0, i_address_broadcast_enable = 1'h0;
  logic i_read_instruction_segment_select = 1'h0;
  logic i_translation_invalidate_sync_n = 1'h1;
  logic [3:0] i_op = 4'h0, i_sr_num = 4'h0;
  logic [9:0] i_spr_num = 10'h0, o_spr_num;
  logic [31:0] i_gpr_data = 32'h0, i_ea = 32'h0, i_saved_msr = 32'h0;
  logic [31:0] i_spr_rdata = 32'h0, o_spr_wdata, o_dc_addr, o_gpr_wdata;
  logic [31:0] o_msr;
  logic o_spr_wr, o_spr_rd, o_dc_invalidate, o_bus_broadcast, o_busy;
  logic o_tlb_invalidate, o_done, o_gpr_we, o_redirect, o_hold_fetch;
  logic o_instruction_translation_enable, o_data_translation_enable;
  logic [5:0] o_tlb_index;
  logic [2:0] o_exception;
  wire [2:0] cmds = {o_dc_invalidate, o_bus_broadcast, o_tlb_invalidate};
  int num_errors = 0, comparisons = 0;
  // Flags: user, block fault, buffer fault, direct store, broadcast.
  sicmc_row_t rows[10] = '{
    '{`SICMC_OP_SYSCALL, 5'h00, 32'h0, `SICMC_EXC_SYSCALL, 3'h0},
    '{`SICMC_OP_DCINV, 5'h01, 32'h1000, `SICMC_EXC_NONE, 3'h6},
    '{`SICMC_OP_DCINV, 5'h00, 32'h1000, `SICMC_EXC_NONE, 3'h4},
    '{`SICMC_OP_DCINV, 5'h0c, 32'h2000, `SICMC_EXC_DSI, 3'h0},
    '{`SICMC_OP_DCINV, 5'h05, 32'h2000, `SICMC_EXC_DSI, 3'h0},
    '{`SICMC_OP_DCINV, 5'h0b, 32'h3000, `SICMC_EXC_NONE, 3'h0},
    '{`SICMC_OP_TLBINV, 5'h00, 32'h3f000, `SICMC_EXC_NONE, 3'h1},
    '{`SICMC_OP_TLBINVALL, 5'h00, 32'h0, `SICMC_EXC_ILLEGAL, 3'h0},
    '{`SICMC_OP_DCINV, 5'h11, 32'h1000, `SICMC_EXC_PRIV, 3'h0},
    '{`SICMC_OP_RETEXC, 5'h00, 32'h0, `SICMC_EXC_NONE, 3'h0}};
  sicmc_core u_dut (.*);
  always #2 i_core_clk = ~i_core_clk;
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Ends with outputs settled just after the edge that shows o_done.
  task automatic run(input logic [3:0] op);
    int n;
    n = 0;
    @(posedge i_core_clk);
    i_op <= op;
    i_issue <= 1'h1;
    @(posedge i_core_clk);
    i_issue <= 1'h0;
    #1;
    while (o_done !== 1'h1 && n < 40) begin
      @(posedge i_core_clk);
      #1;
      n++;
    end
    if (o_done !== 1'h1) begin
      chk("done", 32'h1, o_done);
      test_done();
    end
  endtask
  initial begin
    repeat (20) @(posedge i_core_clk);
    #1;
    chk("reset msr", `SICMC_MSR_RESET, o_msr);
    chk("reset busy", 32'h0, o_busy);
    @(posedge i_core_clk);
    i_rst_n <= 1'h1;
    foreach (rows[k]) begin
      {i_user_mode, i_bat_prot_fault, i_tlb_prot_fault, i_direct_store,
        i_address_broadcast_enable} <= rows[k].f;
      i_ea <= rows[k].ea;
      run(rows[k].op);
      chk("exception", rows[k].ex, o_exception);
      chk("commands", rows[k].o, cmds);
      if (rows[k].o[0]) chk("index", rows[k].ea[17:12], o_tlb_index);
      if (rows[k].o[2]) chk("addr", rows[k].ea, o_dc_addr);
      $display("row %0d done", k);
    end
    i_gpr_data <= 32'h30;
    run(`SICMC_OP_MTMSR);
    chk("ir enable", 32'h1, o_instruction_translation_enable);
    chk("dr enable", 32'h1, o_data_translation_enable);
    run(`SICMC_OP_MFMSR);
    chk("mfmsr", 32'h30, o_gpr_wdata);
    chk("gpr we", 32'h1, o_gpr_we);
    i_sr_num <= 4'h3;
    i_gpr_data <= 32'h00ab_cd12;
    run(`SICMC_OP_MTSR);
    i_sr_indirect <= 1'h1;
    i_ea <= 32'h3000_0000;
    run(`SICMC_OP_MFSR);
    chk("mfsr", 32'h00ab_cd12, o_gpr_wdata);
    i_read_instruction_segment_select <= 1'h1;
    run(`SICMC_OP_MFSR);
    chk("shadow", 32'h00ab_cd12, o_gpr_wdata);
    i_spr_num <= 10'h3f0;
    i_gpr_data <= 32'h2468_ace0;
    run(`SICMC_OP_MTSPR);
    chk("spr num", 32'h3f0, o_spr_num);
    chk("spr wr", 32'h1, o_spr_wr);
    chk("spr data", 32'h2468_ace0, o_spr_wdata);
    i_spr_rdata <= 32'h1357_9bdf;
    run(`SICMC_OP_MFSPR);
    chk("mfspr", 32'h1357_9bdf, o_gpr_wdata);
    $display("move tests done");
    for (int s = 0; s < 64; s++) begin
      i_ea <= {14'h0000, s[5:0], 12'h000};
      run(`SICMC_OP_TLBINV);
      chk("flush index", s, o_tlb_index);
    end
    $display("flush tests done");
    i_pipe_empty <= 1'h0;
    i_translation_invalidate_sync_n <= 1'h0;
    fork
      run(`SICMC_OP_SYSCALL);
      begin
        repeat (7) @(posedge i_core_clk);
        #1;
        chk("hold", 32'h1, o_hold_fetch);
        i_pipe_empty <= 1'h1;
      end
    join
    chk("redirect", 32'h1, o_redirect);
    fork
      run(`SICMC_OP_TLBSYNC);
      begin
        repeat (8) @(posedge i_core_clk);
        #1;
        chk("sync busy", 32'h1, o_busy);
        i_translation_invalidate_sync_n <= 1'h1;
      end
    join
    i_saved_msr <= 32'h10;
    run(`SICMC_OP_RETEXC);
    chk("restored msr", 32'h10, o_msr);
    $display("stall tests done");
    test_done();
  end
endmodule
